// [rtl/cce_regs.sv]
// Purpose: error flags and controls of the bidirectional control channel
// Assumes: event inputs are one-cycle pulses synchronous to clk_sys
// Notes:   APB slave, zero wait states, one setup and one access cycle
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - link fault while master path awaits response sets master link error; read clears
// - watchdog expiry while master path awaits response sets master timeout; read clears
// - link fault while slave path awaits response sets slave link error; read clears
// - watchdog expiry while slave path awaits response sets slave timeout; read clears
// - echoed byte differing from sent byte sets echo mismatch flag; read clears
// - remote disable bit, reset one, blocks local master remote accesses
// - local master accesses to own registers always proceed
// - abort on CRC fault ends transaction only with enhanced checking on
// - internal read ack bit acknowledges start of every remote slave read
// - returned data check bit enables comparing data returned in ack cycles
// - with check on, bad returned data turns remote ack into nack
// - enhanced checking bit enables only termination on CRC fault; error flags are set without it
module cce_regs
	import cce_pkg::*;
#(
	parameter int WDOG_CYC = WDOG_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        master_active,
	input  wire logic        slave_active,
	input  wire logic        frame_sent,
	input  wire logic [7:0]  frame_data,
	input  wire logic        resp_valid,
	input  wire logic [7:0]  resp_data,
	input  wire logic        bc_crc_err,
	input  wire logic        bc_lock_loss,
	input  wire logic        i2c_m_req,
	input  wire logic        i2c_m_req_local,
	input  wire logic        ack_valid,
	input  wire logic [7:0]  ack_data,
	input  wire logic        slave_read_start,
	output var  logic        fwd_remote_req,
	output var  logic        local_reg_req,
	output var  logic        remote_reject,
	output var  logic        abort_xact,
	output var  logic        internal_ack,
	output var  logic        ack_to_local,
	output var  logic        nack_to_local,
	output var  logic        resp_pending
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  status;
		logic [7:0]  cfg;
		logic [7:0]  rd_clr;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        pending;
		logic        pend_master;
		logic        pend_slave;
		logic [7:0]  sent_data;
		logic        fwd_remote_req;
		logic        local_reg_req;
		logic        remote_reject;
		logic        abort_xact;
		logic        internal_ack;
		logic        ack_to_local;
		logic        nack_to_local;
	} cce_state_t;

	cce_state_t q;
	cce_state_t next_q;
	logic       wdog_expire;

	function automatic logic is_status(input logic [11:0] a);
		return a == ADDR_STATUS;
	endfunction

	function automatic logic is_config(input logic [11:0] a);
		return a == ADDR_CONFIG;
	endfunction

	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	cce_watchdog #(
		.WDOG_CYC (WDOG_CYC)
	) u_wdog (
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (q.pending),
		.restart (frame_sent),
		.expire  (wdog_expire)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	logic       setup;
	logic       done;
	logic       link_fault;
	logic       crc_abort;
	logic [7:0] set_bits;
	logic [7:0] clr_bits;

	always_comb begin
		next_q     = q;
		setup      = psel && !penable;
		done       = psel && penable && q.pready;
		link_fault = q.pending && (bc_crc_err || bc_lock_loss);
		crc_abort  = q.pending && bc_crc_err && q.cfg[CF_ABORT_ON_CRC] && q.cfg[CF_ENH_CHECK];
		set_bits   = 8'h00;
		clr_bits   = 8'h00;

		next_q.fwd_remote_req = 1'b0;
		next_q.local_reg_req  = 1'b0;
		next_q.remote_reject  = 1'b0;
		next_q.abort_xact     = 1'b0;
		next_q.internal_ack   = 1'b0;
		next_q.ack_to_local   = 1'b0;
		next_q.nack_to_local  = 1'b0;

		// flag sources
		set_bits[ST_MASTER_LINK_ERR] = link_fault && q.pend_master;
		set_bits[ST_MASTER_TIMEOUT]  = wdog_expire && q.pend_master;
		set_bits[ST_SLAVE_LINK_ERR]  = link_fault && q.pend_slave;
		set_bits[ST_SLAVE_TIMEOUT]   = wdog_expire && q.pend_slave;
		set_bits[ST_ECHO_MISMATCH]   = q.pending && resp_valid && resp_data != q.sent_data;

		// response tracking for the watchdog
		if (frame_sent) begin
			next_q.pending     = 1'b1;
			next_q.pend_master = master_active;
			next_q.pend_slave  = slave_active;
			next_q.sent_data   = frame_data;
		end else if (resp_valid || wdog_expire || crc_abort) begin
			next_q.pending     = 1'b0;
			next_q.pend_master = 1'b0;
			next_q.pend_slave  = 1'b0;
		end
		next_q.abort_xact = crc_abort;

		// local master routing
		if (i2c_m_req) begin
			if (i2c_m_req_local) begin
				next_q.local_reg_req = 1'b1;
			end else if (q.cfg[CF_REMOTE_DISABLE]) begin
				next_q.remote_reject = 1'b1;
			end else begin
				next_q.fwd_remote_req = 1'b1;
			end
		end

		next_q.internal_ack = slave_read_start && q.cfg[CF_INT_READ_ACK];

		// returned data in ack cycles
		if (ack_valid) begin
			if (q.cfg[CF_DATA_CHECK] && ack_data != q.sent_data) begin
				next_q.nack_to_local = 1'b1;
			end else begin
				next_q.ack_to_local = 1'b1;
			end
		end

		// apb: answer is prepared in setup, committed in access
		next_q.pready = setup;
		if (setup) begin
			next_q.pslverr = 1'b0;
			next_q.rd_clr  = 8'h00;
			if (is_status(paddr)) begin
				next_q.prdata = {24'h00_0000, q.status};
				if (!pwrite) begin
					next_q.rd_clr = q.status & STATUS_FLAGS;
				end
			end else if (is_config(paddr)) begin
				next_q.prdata = {24'h00_0000, q.cfg};
			end else begin
				next_q.prdata  = 32'h0000_0000;
				next_q.pslverr = 1'b1;
			end
		end

		if (done) begin
			if (!pwrite) begin
				// only what was shown is cleared, so a late event is kept
				clr_bits = q.rd_clr;
			end else if (is_status(paddr)) begin
				next_q.status = (pwdata[7:0] & STATUS_WMASK) | (q.status & ~STATUS_WMASK);
			end else if (is_config(paddr)) begin
				next_q.cfg = (pwdata[7:0] & CONFIG_WMASK) | (q.cfg & ~CONFIG_WMASK);
			end
		end

		// set wins over clear-on-read
		next_q.status = (next_q.status & ~clr_bits) | set_bits;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q        <= '0;
			q.status <= STATUS_RESET;
			q.cfg    <= CONFIG_RESET;
		end else begin
			q <= next_q;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign prdata         = q.prdata;
	assign pready         = q.pready;
	assign pslverr        = q.pslverr;
	assign fwd_remote_req = q.fwd_remote_req;
	assign local_reg_req  = q.local_reg_req;
	assign remote_reject  = q.remote_reject;
	assign abort_xact     = q.abort_xact;
	assign internal_ack   = q.internal_ack;
	assign ack_to_local   = q.ack_to_local;
	assign nack_to_local  = q.nack_to_local;
	assign resp_pending   = q.pending;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_master_fault;
		q.pending && q.pend_master && (bc_crc_err || bc_lock_loss);
	endsequence

	sequence s_slave_fault;
		q.pending && q.pend_slave && (bc_crc_err || bc_lock_loss);
	endsequence

	property p_master_err;
		@(posedge clk_sys) disable iff (rst)
		s_master_fault |=> q.status[ST_MASTER_LINK_ERR];
	endproperty
	a_master_err: assert property (p_master_err) else $error("master link error not flagged");

	property p_master_to;
		@(posedge clk_sys) disable iff (rst)
		wdog_expire && q.pend_master && !frame_sent |=> q.status[ST_MASTER_TIMEOUT] && !q.pending;
	endproperty
	a_master_to: assert property (p_master_to) else $error("master timeout not flagged");

	property p_slave_err;
		@(posedge clk_sys) disable iff (rst)
		s_slave_fault |=> q.status[ST_SLAVE_LINK_ERR];
	endproperty
	a_slave_err: assert property (p_slave_err) else $error("slave link error not flagged");

	property p_slave_to;
		@(posedge clk_sys) disable iff (rst)
		wdog_expire && q.pend_slave |=> q.status[ST_SLAVE_TIMEOUT];
	endproperty
	a_slave_to: assert property (p_slave_to) else $error("slave timeout not flagged");

	property p_echo;
		@(posedge clk_sys) disable iff (rst)
		q.pending && resp_valid && resp_data != q.sent_data |=> q.status[ST_ECHO_MISMATCH];
	endproperty
	a_echo: assert property (p_echo) else $error("echo mismatch not flagged");

	sequence s_status_read;
		psel && !penable && !pwrite && is_status(paddr) ##1 psel && penable;
	endsequence

	property p_read_clear;
		@(posedge clk_sys) disable iff (rst)
		s_status_read ##0 !frame_sent && !q.pending && !wdog_expire |=> (q.status & $past(q.rd_clr)) == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");

	property p_remote_block;
		@(posedge clk_sys) disable iff (rst)
		i2c_m_req && !i2c_m_req_local && q.cfg[CF_REMOTE_DISABLE] |=> remote_reject && !fwd_remote_req;
	endproperty
	a_remote_block: assert property (p_remote_block) else $error("remote access not blocked");

	property p_local_ok;
		@(posedge clk_sys) disable iff (rst)
		i2c_m_req && i2c_m_req_local |=> local_reg_req && !remote_reject;
	endproperty
	a_local_ok: assert property (p_local_ok) else $error("local access refused");

	property p_abort;
		@(posedge clk_sys) disable iff (rst)
		q.pending && bc_crc_err && !frame_sent && q.cfg[CF_ABORT_ON_CRC] && q.cfg[CF_ENH_CHECK]
			|=> abort_xact && !resp_pending;
	endproperty
	a_abort: assert property (p_abort) else $error("crc fault did not abort");

	property p_no_abort;
		@(posedge clk_sys) disable iff (rst)
		!q.cfg[CF_ENH_CHECK] |=> !abort_xact;
	endproperty
	a_no_abort: assert property (p_no_abort) else $error("abort without enhanced checking");

	property p_int_ack;
		@(posedge clk_sys) disable iff (rst)
		slave_read_start |=> internal_ack == $past(q.cfg[CF_INT_READ_ACK]);
	endproperty
	a_int_ack: assert property (p_int_ack) else $error("internal read ack wrong");

	property p_nack;
		@(posedge clk_sys) disable iff (rst)
		ack_valid && q.cfg[CF_DATA_CHECK] && ack_data != q.sent_data |=> nack_to_local && !ack_to_local;
	endproperty
	a_nack: assert property (p_nack) else $error("bad returned data not nacked");

	property p_no_check;
		@(posedge clk_sys) disable iff (rst)
		ack_valid && !q.cfg[CF_DATA_CHECK] |=> ack_to_local && !nack_to_local;
	endproperty
	a_no_check: assert property (p_no_check) else $error("data checked while disabled");

endmodule // cce_regs
`default_nettype wire

// [rtl/cce_pkg.sv]
// Purpose: constants for the control channel error register bank
// Assumes: 200 MHz register clock, APB with 32-bit data
// Notes:   printed offsets are word indexes; byte address is index times four
package cce_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 5;
	localparam int WDOG_TIMEOUT_NS = 100000;
	localparam int WDOG_CYCLES     = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [11:0] IDX_STATUS  = 12'h06d;
	localparam logic [11:0] IDX_CONFIG  = 12'h06e;
	localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'b00};
	localparam logic [11:0] ADDR_CONFIG = {IDX_CONFIG[9:0], 2'b00};

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h20;
	localparam logic [7:0] STATUS_WMASK = 8'he0;
	localparam logic [7:0] STATUS_FLAGS = 8'h1f;
	localparam logic [7:0] CONFIG_WMASK = 8'h3f;

	// status fields
	localparam int ST_MASTER_LINK_ERR = 4;
	localparam int ST_MASTER_TIMEOUT  = 3;
	localparam int ST_SLAVE_LINK_ERR  = 2;
	localparam int ST_SLAVE_TIMEOUT   = 1;
	localparam int ST_ECHO_MISMATCH   = 0;

	// config fields
	localparam int CF_REMOTE_DISABLE  = 5;
	localparam int CF_ABORT_ON_CRC    = 4;
	localparam int CF_INT_READ_ACK    = 2;
	localparam int CF_DATA_CHECK      = 1;
	localparam int CF_ENH_CHECK       = 0;

endpackage

// [rtl/cce_watchdog.sv]
// Purpose: channel watchdog, counts while a remote response is pending
// Assumes: run is a level, restart a one-cycle pulse
// Notes:   expire is a one-cycle registered pulse
`timescale 1ns/100ps
`default_nettype none
module cce_watchdog #(
	parameter int WDOG_CYC = 20000
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic run,
	input  wire logic restart,
	output var  logic expire
);

	localparam logic [31:0] LAST = 32'(WDOG_CYC - 1);

	typedef struct packed {
		logic [31:0] cnt;
		logic        expire;
	} cce_wd_state_t;

	cce_wd_state_t q;
	cce_wd_state_t next_q;

	always_comb begin
		next_q        = q;
		next_q.expire = 1'b0;
		if (!run || restart) begin
			next_q.cnt = 32'h0000_0000;
		end else if (q.cnt == LAST) begin
			next_q.cnt    = 32'h0000_0000;
			next_q.expire = 1'b1;
		end else begin
			next_q.cnt = q.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign expire = q.expire;

	property p_wd_expire;
		@(posedge clk_sys) disable iff (rst)
		run && !restart && q.cnt == LAST |=> expire && q.cnt == 32'h0000_0000;
	endproperty
	a_wd_expire: assert property (p_wd_expire) else $error("watchdog missed expiry");

	property p_wd_quiet;
		@(posedge clk_sys) disable iff (rst)
		!run |=> !expire;
	endproperty
	a_wd_quiet: assert property (p_wd_quiet) else $error("watchdog fired while idle");

endmodule // cce_watchdog
`default_nettype wire

// [tb/cce_remote_model.sv]
// Purpose: remote end of the control channel, answers each forward frame
// Assumes: frame_sent is a one-cycle pulse; a delay of zero is taken as one
// Notes:   corrupt flips echo bit 0; mute drops the answer so the watchdog runs
`timescale 1ns/100ps
`default_nettype none
module cce_remote_model (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       frame_sent,
	input  wire logic [7:0] frame_data,
	input  wire logic [7:0] dly,
	input  wire logic       corrupt,
	input  wire logic       mute,
	output var  logic       resp_valid,
	output var  logic [7:0] resp_data
);
	logic [7:0] cnt;
	logic [7:0] held;
	// ------------------------------
	// answer timing
	// ------------------------------
	always @(posedge clk_sys) begin
		resp_valid <= 1'b0;
		resp_data  <= ~resp_data;  // idle bus toggles so a stale echo never passes
		if (rst) begin
			cnt       <= 8'h00;
			resp_data <= 8'h00;
		end else if (frame_sent && !mute) begin
			cnt  <= (dly == 8'h00) ? 8'h01 : dly;
			held <= frame_data ^ {7'h00, corrupt};
		end else if (cnt == 8'h01) begin
			cnt        <= 8'h00;
			resp_valid <= 1'b1;
			resp_data  <= held;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end
	end
endmodule // cce_remote_model
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for the control channel error registers
// Assumes: zero wait state APB slave, result pulses one cycle after cause
// Notes:   watchdog shortened to 20 cycles so timeouts stay cheap
`timescale 1ns/100ps
`default_nettype none
module tb
	import cce_pkg::*;
;
	// ------------------------------
	// signals and parts
	// ------------------------------
	localparam int WD = 20;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0]  ev;  // srd, ackv, mreq, lock, crc, frame
	logic [4:0]  lv;  // master, slave, local, mute, corrupt
	logic [7:0]  fd, dly, resp_data;
	logic        resp_valid, fwd, lreg, rej, abrt, iack, ackl, nackl, pend;
	int          n_fail, cmp_count;

	cce_regs #(.WDOG_CYC(WD)) uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.master_active(lv[4]), .slave_active(lv[3]), .frame_sent(ev[0]), .frame_data(fd),
		.resp_valid(resp_valid), .resp_data(resp_data), .bc_crc_err(ev[1]), .bc_lock_loss(ev[2]),
		.i2c_m_req(ev[3]), .i2c_m_req_local(lv[2]), .ack_valid(ev[4]), .ack_data(fd),
		.slave_read_start(ev[5]), .fwd_remote_req(fwd), .local_reg_req(lreg), .remote_reject(rej),
		.abort_xact(abrt), .internal_ack(iack), .ack_to_local(ackl), .nack_to_local(nackl), .resp_pending(pend));
	cce_remote_model rem (.clk_sys(clk_sys), .rst(rst), .frame_sent(ev[0]), .frame_data(fd), .dly(dly),
		.corrupt(lv[0]), .mute(lv[1]), .resp_valid(resp_valid), .resp_data(resp_data));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// ------------------------------
	// bus and check tasks
	// ------------------------------
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// no local limit: a slave that never answers is caught by the 5000-cycle bench time limit
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, x, r);
		chk("pslverr", {31'h0, a != ADDR_STATUS && a != ADDR_CONFIG}, {31'h0, e});
	endtask
	task automatic pulse(input logic [5:0] m, input logic [7:0] d, input logic [4:0] l);
		@(posedge clk_sys);
		ev <= m;
		fd <= d;
		lv <= l;
		@(posedge clk_sys);
		ev <= 6'h00;
		#1;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_regs;
		rd("status", ADDR_STATUS, 32'h00);
		rd("config", ADDR_CONFIG, 32'h20);
		rd("unmapped", 12'h1bc, 32'h00);
		wr(ADDR_CONFIG, 32'hff);
		rd("config", ADDR_CONFIG, 32'h3f);
		wr(ADDR_STATUS, 32'hff);
		rd("status", ADDR_STATUS, 32'he0);
		wr(ADDR_STATUS, 32'h00);
		wr(ADDR_CONFIG, 32'h20);
		$display("regs test done");
	endtask
	task automatic t_echo;
		for (int i = 0; i < 2; i++) begin
			dly <= i ? 8'h01 : 8'h08;
			pulse(6'h01, 8'h5a, {4'b1000, i[0]});
			chk("pending", 1, pend);
			idle(12);
			chk("pending", 0, pend);
			rd("status", ADDR_STATUS, {31'h0, i[0]});
		end
		rd("status", ADDR_STATUS, 32'h0);
		$display("echo test done");
	endtask
	task automatic t_link;
		for (int i = 0; i < 4; i++) begin
			pulse(6'h01, 8'h11, i[0] ? 5'b01010 : 5'b10010);
			pulse(i[1] ? 6'h04 : 6'h02, 8'h11, i[0] ? 5'b01010 : 5'b10010);
			idle(WD - 5);
			chk("pending", 1, pend);
			idle(6);
			chk("pending", 0, pend);
			rd("status", ADDR_STATUS, i[0] ? 32'h06 : 32'h18);
			rd("status", ADDR_STATUS, 32'h00);
		end
		pulse(6'h06, 8'h11, 5'b10000);
		rd("status", ADDR_STATUS, 32'h00);
		$display("link test done");
	endtask
	task automatic t_abort;
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CONFIG, {26'h0, 1'b1, i[1], 3'b000, i[0]});
			pulse(6'h01, 8'h22, 5'b10010);
			pulse(6'h02, 8'h22, 5'b10010);
			chk("abort", i == 3, abrt);
			idle(WD + 4);
			rd("status", ADDR_STATUS, i == 3 ? 32'h10 : 32'h18);
		end
		$display("abort test done");
	endtask
	task automatic t_access;
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CONFIG, i[1] ? 32'h20 : 32'h00);
			pulse(6'h08, 8'h00, {2'b00, i[0], 2'b00});
			chk("access", {29'h0, ~i[0] & ~i[1], i[0], ~i[0] & i[1]}, {29'h0, fwd, lreg, rej});
		end
		$display("access test done");
	endtask
	task automatic t_rdack;
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_CONFIG, i ? 32'h24 : 32'h20);
			pulse(6'h20, 8'h00, 5'b01000);
			chk("internal ack", i, iack);
		end
		$display("read ack test done");
	endtask
	task automatic t_datachk;
		dly <= 8'h08;
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CONFIG, i[1] ? 32'h22 : 32'h20);
			pulse(6'h01, 8'h3c, 5'b10000);
			pulse(6'h10, 8'h3c ^ {7'h0, i[0]}, 5'b10000);
			chk("ack answer", {30'h0, ~(i[1] & i[0]), i[1] & i[0]}, {30'h0, ackl, nackl});
			idle(10);
			rd("status", ADDR_STATUS, 32'h00);
		end
		$display("data check test done");
	endtask
	// ------------------------------
	// run
	// ------------------------------
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, ev, lv, fd} = '0;
		dly = 8'h01;
		rst = 1'b1;
		n_fail = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs;
		t_echo;
		t_link;
		t_abort;
		t_access;
		t_rdack;
		t_datachk;
		conclude;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		conclude;
	end
endmodule // tb
`default_nettype wire
